// File: src/spl_pkg.sv
// shared constants and types for the stack pointer limit checker
package spl_pkg;

  // ****************************************
  // widths and fixed addresses
  // ****************************************
  localparam int SPL_AW = 16;
  localparam logic [15:0] SPL_SFR_FLOOR = 16'h0800;
  localparam logic [15:0] SPL_SP_RESET = 16'h0800;
  localparam logic [15:0] SPL_WORD_STEP = 16'h0002;
  localparam int SPL_ALIGN_BIT = 0;
  localparam int SPL_CALL_MSB = 15;
  localparam int SPL_SRL_LSB = 8;

  // ****************************************
  // secure ram windows (defaults only)
  // ****************************************
  localparam logic [15:0] SPL_BOOT_RAM_LO = 16'h0800;
  localparam logic [15:0] SPL_BOOT_RAM_HI = 16'h08fe;
  localparam logic [15:0] SPL_SEC_RAM_LO = 16'h0900;
  localparam logic [15:0] SPL_SEC_RAM_HI = 16'h09fe;

  // ****************************************
  // kinds of push
  // ****************************************
  typedef enum logic [1:0] {
    SPL_PUSH_PLAIN = 2'b00,
    SPL_PUSH_CALL_HI = 2'b01,
    SPL_PUSH_EXC_HI = 2'b10
  } spl_push_kind_t;

endpackage

// File: src/spl_stack_ram.sv
// stack word memory with registered read data
`timescale 1ns/1ns
module spl_stack_ram #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic sys_clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData_r
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // no reset: contents are don't-care until pushed
  always_ff @(posedge sys_clk) begin
    if (rdEn) begin
      rdData_r <= mem[rdAddr];
    end
  end

endmodule

// File: src/spl_stack_checker.sv
// stack pointer, push/pop engine, stack bound checks and secure ram guard
//
// Contract
// - one working register also serves as the software stack pointer.
// - stack pointer always holds the address of the next free word.
// - stack grows upward; each push raises the pointer.
// - push writes at pointer then increments; pop decrements then reads.
// - call pushes force the upper pc word msb to zero.
// - exception pushes place the status low byte in the upper bits.
// - limit register is not touched by any reset.
// - limit register bit 0 reads zero once the register has been written.
// - stack pointer lowest bit kept zero for all stack operations.
// - every address built from the stack pointer is checked against the limit once the limit has been written since the last reset.
// - push at pointer equal to limit passes; the next push traps.
// - address below the fixed floor raises an underflow trap.
// - boot secure ram reachable only from boot flash code when enabled.
// - secure segment ram reachable only from secure flash code when enabled.
`timescale 1ns/1ns
module spl_stack_checker
  import spl_pkg::*;
#(
  parameter int DEPTH_LOG2 = 6,
  parameter logic [15:0] BOOT_RAM_LO = SPL_BOOT_RAM_LO,
  parameter logic [15:0] BOOT_RAM_HI = SPL_BOOT_RAM_HI,
  parameter logic [15:0] SEC_RAM_LO = SPL_SEC_RAM_LO,
  parameter logic [15:0] SEC_RAM_HI = SPL_SEC_RAM_HI
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic spWrEn,
  input wire logic [15:0] spWrData,
  input wire logic limWrEn,
  input wire logic [15:0] limWrData,
  input wire logic pushReq,
  input wire logic [1:0] pushKind,
  input wire logic [15:0] pushData,
  input wire logic [7:0] statusLowByte,
  input wire logic popReq,
  input wire logic eaReq,
  input wire logic [15:0] eaAddr,
  input wire logic dataReq,
  input wire logic [15:0] dataAddr,
  input wire logic bootRamEn,
  input wire logic secRamEn,
  input wire logic codeInBoot,
  input wire logic codeInSecure,
  output logic [15:0] stackPtr_r,
  output logic [15:0] stackLimit_r,
  output logic [15:0] effAddr_r,
  output logic effAddrValid_r,
  output logic stackErr_r,
  output logic overflowErr_r,
  output logic underflowErr_r,
  output logic [15:0] popData,
  output logic popValid_r,
  output logic accessDenied_r
);

  // ****************************************
  // helpers
  // ****************************************
  // bit 1 = overflow, bit 0 = underflow
  function automatic logic [1:0] stackFault(input logic [15:0] ea, input logic [15:0] lim,
                                            input logic limKnown);
    logic [1:0] f;
    f = 2'b00;
    f[1] = limKnown && (ea > lim);
    f[0] = ea < SPL_SFR_FLOOR;
    return f;
  endfunction

  function automatic logic inWindow(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  spl_push_kind_t kind;
  logic doPush;
  logic doPop;
  logic doEa;
  logic [15:0] spDec;
  logic [15:0] spInc;
  logic [15:0] checkEa;
  logic [1:0] fault;
  logic [15:0] pushWord;
  logic limKnown_r;
  logic bootBad;
  logic secBad;

  // ****************************************
  // request decode
  // ****************************************
  // push wins over pop; a plain address check is dropped while a push or pop is requested
  always_comb begin
    kind = spl_push_kind_t'(pushKind);
    doPush = pushReq;
    doPop = popReq && !pushReq;
    doEa = eaReq && !pushReq && !popReq;
    spInc = stackPtr_r + SPL_WORD_STEP;
    spDec = stackPtr_r - SPL_WORD_STEP;
  end

  // ****************************************
  // pushed word shaping
  // ****************************************
  always_comb begin
    pushWord = pushData;
    unique case (kind)
      SPL_PUSH_PLAIN: pushWord = pushData;
      SPL_PUSH_CALL_HI: pushWord[SPL_CALL_MSB] = 1'b0;
      SPL_PUSH_EXC_HI: pushWord[15:SPL_SRL_LSB] = statusLowByte;
      default: pushWord = pushData;
    endcase
  end

  // ****************************************
  // stack pointer register
  // ****************************************
  // the same register also takes ordinary working-register writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stackPtr_r <= SPL_SP_RESET;
    end else if (doPush) begin
      stackPtr_r <= spInc;
    end else if (doPop) begin
      stackPtr_r <= spDec;
    end else if (spWrEn) begin
      stackPtr_r <= {spWrData[15:1], 1'b0};
    end
  end

  // ****************************************
  // limit register
  // ****************************************
  // deliberately no reset branch: contents stay unknown until written
  always_ff @(posedge sys_clk) begin
    if (limWrEn) begin
      stackLimit_r <= {limWrData[15:1], 1'b0};
    end
  end

  // overflow checks are held off until the limit has been written since the last reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      limKnown_r <= 1'b0;
    end else if (limWrEn) begin
      limKnown_r <= 1'b1;
    end
  end

  // ****************************************
  // effective address and bound check
  // ****************************************
  always_comb begin
    checkEa = eaAddr;
    if (doPush) begin
      checkEa = stackPtr_r;
    end else if (doPop) begin
      checkEa = spDec;
    end
    fault = stackFault(checkEa, stackLimit_r, limKnown_r);
  end

  // error flags share the edge that presents the address
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      effAddr_r <= SPL_SP_RESET;
      effAddrValid_r <= 1'b0;
      stackErr_r <= 1'b0;
      overflowErr_r <= 1'b0;
      underflowErr_r <= 1'b0;
    end else begin
      effAddrValid_r <= doPush || doPop || doEa;
      if (doPush || doPop || doEa) begin
        effAddr_r <= checkEa;
      end
      stackErr_r <= (doPush || doPop || doEa) && (fault != 2'b00);
      overflowErr_r <= (doPush || doPop || doEa) && fault[1];
      underflowErr_r <= (doPush || doPop || doEa) && fault[0];
    end
  end

  // ****************************************
  // stack memory
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      popValid_r <= 1'b0;
    end else begin
      popValid_r <= doPop;
    end
  end

  spl_stack_ram #(
    .AW(DEPTH_LOG2),
    .DW(16)
  ) u_ram (
    .sys_clk(sys_clk),
    .wrEn(doPush),
    .wrAddr(stackPtr_r[DEPTH_LOG2:1]),
    .wrData(pushWord),
    .rdEn(doPop),
    .rdAddr(spDec[DEPTH_LOG2:1]),
    .rdData_r(popData)
  );

  // ****************************************
  // secure ram guard
  // ****************************************
  always_comb begin
    bootBad = bootRamEn && inWindow(dataAddr, BOOT_RAM_LO, BOOT_RAM_HI) && !codeInBoot;
    secBad = secRamEn && inWindow(dataAddr, SEC_RAM_LO, SEC_RAM_HI) && !codeInSecure;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      accessDenied_r <= 1'b0;
    end else begin
      accessDenied_r <= dataReq && (bootBad || secBad);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sp_aligned_a: assert property (stackPtr_r[SPL_ALIGN_BIT] == 1'b0)
    else $error("stack pointer lost word alignment");

  lim_bit0_a: assert property (limKnown_r |-> stackLimit_r[SPL_ALIGN_BIT] == 1'b0)
    else $error("limit bit 0 not zero");

  push_incr_a: assert property (pushReq |=> stackPtr_r == $past(stackPtr_r) + SPL_WORD_STEP
                                && effAddr_r == $past(stackPtr_r))
    else $error("push did not write at pointer and step up by one word");

  pop_decr_a: assert property ((popReq && !pushReq) |=>
                               stackPtr_r == $past(stackPtr_r) - SPL_WORD_STEP
                               && effAddr_r == stackPtr_r && popValid_r)
    else $error("pop did not step down before reading");

  under_trap_a: assert property (effAddrValid_r && effAddr_r < SPL_SFR_FLOOR |->
                                 stackErr_r && underflowErr_r)
    else $error("address below floor without underflow trap");

  // a push at the limit still lands in a legal word; only the one beyond traps
  over_edge_a: assert property (pushReq && limKnown_r && stackPtr_r == stackLimit_r
                                |=> !overflowErr_r)
    else $error("push at the limit raised an overflow");

  over_trap_a: assert property (pushReq && limKnown_r && stackPtr_r > stackLimit_r
                                |=> stackErr_r && overflowErr_r)
    else $error("push beyond the limit without overflow trap");

  err_pulse_a: assert property (stackErr_r |-> effAddrValid_r
                                && (overflowErr_r || underflowErr_r))
    else $error("stack error without a checked address");

  // the flags were judged against the limit of the request cycle
  no_false_a: assert property (effAddrValid_r && effAddr_r >= SPL_SFR_FLOOR
                               && (!$past(limKnown_r) || effAddr_r <= $past(stackLimit_r))
                               |-> !stackErr_r)
    else $error("stack error raised inside bounds");

  call_word_a: assert property (pushReq && pushKind == 2'b01
                                |-> pushWord == {1'b0, pushData[14:0]})
    else $error("call push kept upper msb");

  exc_word_a: assert property (pushReq && pushKind == 2'b10
                               |-> pushWord == {statusLowByte, pushData[7:0]})
    else $error("exception push lost the status byte");

  secure_ram_a: assert property (dataReq && secRamEn && !codeInSecure
                                 && dataAddr >= SEC_RAM_LO && dataAddr <= SEC_RAM_HI
                                 |=> accessDenied_r)
    else $error("secure segment ram reached from foreign code");

  boot_ram_a: assert property (dataReq && bootRamEn && !codeInBoot
                               && dataAddr >= BOOT_RAM_LO && dataAddr <= BOOT_RAM_HI
                               |=> accessDenied_r)
    else $error("boot secure ram reached from foreign code");

  ea_check_a: assert property (eaReq && !pushReq && !popReq
                               |=> effAddrValid_r && effAddr_r == $past(eaAddr))
    else $error("requested address not presented for checking");

  // ordinary register writes lose to push and pop in the same cycle
  sp_write_a: assert property (spWrEn && !pushReq && !popReq
                               |=> stackPtr_r == {$past(spWrData[15:1]), 1'b0})
    else $error("working register write to the pointer lost");

  lim_write_a: assert property (limWrEn
                                |=> stackLimit_r == {$past(limWrData[15:1]), 1'b0})
    else $error("limit write did not land with bit 0 cleared");

  // a refusal must trace back to a guarded window hit one edge earlier
  deny_only_a: assert property (accessDenied_r |-> $past(dataReq)
                                && ($past(bootBad) || $past(secBad)))
    else $error("access refused without a guarded window hit");

endmodule

// File: verification/spl_core_model.sv
// core-side model: exception intake that counts stack traps
`timescale 1ns/1ns
module spl_core_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic limWrEn,
  input wire logic eaReq,
  input wire logic stackErr_r,
  output int trapCount,
  output int hazardCount
);
  logic limWrD_r;
  // ****************************************
  // trap intake and hazard watch
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trapCount <= 0;
    end else if (stackErr_r) begin
      trapCount <= trapCount + 1;
    end
  end
  // an address check request (eaReq) one cycle after a limit write is a fault of the core
  always_ff @(posedge sys_clk) begin
    limWrD_r <= limWrEn;
    if (srst) begin
      hazardCount <= 0;
    end else if (limWrD_r && eaReq) begin
      hazardCount <= hazardCount + 1;
    end
  end
endmodule

// File: verification/testbench.sv
// self-checking bench for the stack pointer limit checker
`timescale 1ns/1ns
module testbench;
  import spl_pkg::*;
  logic sys_clk = 0, srst = 1, spWrEn = 0, limWrEn = 0, pushReq = 0, popReq = 0, eaReq = 0;
  logic dataReq = 0, bootRamEn = 0, secRamEn = 0, codeInBoot = 0, codeInSecure = 0;
  logic [1:0] pushKind = 2'h0;
  logic [7:0] statusLowByte = 8'h5a;
  logic [15:0] spWrData = 16'h0, limWrData = 16'h0, pushData = 16'h0;
  logic [15:0] eaAddr = 16'h0, dataAddr = 16'h0;
  logic [15:0] stackPtr_r, stackLimit_r, effAddr_r, popData;
  logic effAddrValid_r, stackErr_r, overflowErr_r, underflowErr_r, popValid_r, accessDenied_r;
  int numErrors = 0, nChecks = 0, cycles = 0, trapCount, hazardCount;
  always #25 sys_clk = ~sys_clk;
  spl_stack_checker i_dut (.sys_clk(sys_clk), .srst(srst), .spWrEn(spWrEn),
    .spWrData(spWrData), .limWrEn(limWrEn), .limWrData(limWrData), .pushReq(pushReq),
    .pushKind(pushKind), .pushData(pushData), .statusLowByte(statusLowByte),
    .popReq(popReq), .eaReq(eaReq), .eaAddr(eaAddr), .dataReq(dataReq),
    .dataAddr(dataAddr), .bootRamEn(bootRamEn), .secRamEn(secRamEn),
    .codeInBoot(codeInBoot), .codeInSecure(codeInSecure), .stackPtr_r(stackPtr_r),
    .stackLimit_r(stackLimit_r), .effAddr_r(effAddr_r), .effAddrValid_r(effAddrValid_r),
    .stackErr_r(stackErr_r), .overflowErr_r(overflowErr_r),
    .underflowErr_r(underflowErr_r), .popData(popData), .popValid_r(popValid_r),
    .accessDenied_r(accessDenied_r));
  spl_core_model i_core (.sys_clk(sys_clk), .srst(srst), .limWrEn(limWrEn),
    .eaReq(eaReq), .stackErr_r(stackErr_r), .trapCount(trapCount),
    .hazardCount(hazardCount));
  // ****************************************
  // shared tasks
  // ****************************************
  task endSim;
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      endSim;
    end
  end
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    nChecks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      numErrors++;
    end
  endtask
  // requests change on the falling edge; a following call overrides, never clears twice
  task cyc(input logic p, input logic [1:0] k, input logic [15:0] d, input logic q,
           input logic e, input logic [15:0] a);
    pushReq = p;
    pushKind = k;
    pushData = d;
    popReq = q;
    eaReq = e;
    eaAddr = a;
    @(negedge sys_clk);
  endtask
  task errs(input logic [2:0] exp);
    chk("errors", {13'h0, exp}, {13'h0, stackErr_r, overflowErr_r, underflowErr_r});
  endtask
  task acc(input logic be, input logic cb, input logic se, input logic cs,
           input logic [15:0] a, input logic exp);
    bootRamEn = be;
    codeInBoot = cb;
    secRamEn = se;
    codeInSecure = cs;
    dataReq = 1;
    dataAddr = a;
    @(negedge sys_clk);
    chk("accessDenied", {15'h0, exp}, {15'h0, accessDenied_r});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task tPushPop;
    limWrEn = 1;
    limWrData = 16'h0811;
    @(negedge sys_clk);
    limWrEn = 0;
    chk("stackLimit", 16'h0810, stackLimit_r);
    cyc(1, SPL_PUSH_PLAIN, 16'h1234, 0, 0, 0);
    chk("sp", 16'h0802, stackPtr_r);
    chk("ea", 16'h0800, effAddr_r);
    errs(3'b000);
    cyc(1, SPL_PUSH_CALL_HI, 16'hffff, 0, 0, 0);
    chk("sp", 16'h0804, stackPtr_r);
    cyc(1, SPL_PUSH_EXC_HI, 16'hc3c3, 0, 0, 0);
    chk("valid", 16'h1, {15'h0, effAddrValid_r});
    cyc(1, 2'h3, 16'hf00d, 0, 0, 0);
    cyc(0, 0, 0, 1, 0, 0);
    chk("popData", 16'hf00d, popData);
    cyc(0, 0, 0, 1, 0, 0);
    chk("sp", 16'h0804, stackPtr_r);
    chk("popData", 16'h5ac3, popData);
    cyc(0, 0, 0, 1, 0, 0);
    chk("popData", 16'h7fff, popData);
    cyc(0, 0, 0, 1, 0, 0);
    chk("popData", 16'h1234, popData);
    chk("popValid", 16'h1, {15'h0, popValid_r});
    cyc(0, 0, 0, 0, 0, 0);
    chk("popValid", 16'h0, {15'h0, popValid_r});
    $display("test push_pop done");
  endtask
  task tBounds;
    spWrEn = 1;
    spWrData = 16'h0811;
    @(negedge sys_clk);
    spWrEn = 0;
    chk("sp", 16'h0810, stackPtr_r);
    cyc(1, SPL_PUSH_PLAIN, 16'h0001, 0, 0, 0);
    errs(3'b000);
    cyc(1, SPL_PUSH_PLAIN, 16'h0002, 0, 0, 0);
    errs(3'b110);
    chk("ea", 16'h0812, effAddr_r);
    cyc(0, 0, 0, 0, 1, 16'h0808);
    errs(3'b000);
    chk("ea", 16'h0808, effAddr_r);
    cyc(0, 0, 0, 0, 1, 16'h0c00);
    errs(3'b110);
    cyc(0, 0, 0, 0, 1, 16'h0700);
    errs(3'b101);
    spWrEn = 1;
    spWrData = 16'h0800;
    cyc(0, 0, 0, 0, 0, 0);
    spWrEn = 0;
    cyc(0, 0, 0, 1, 0, 0);
    chk("sp", 16'h07fe, stackPtr_r);
    errs(3'b101);
    cyc(0, 0, 0, 0, 0, 0);
    chk("traps", 16'h4, trapCount[15:0]);
    chk("hazards", 16'h0, hazardCount[15:0]);
    $display("test bounds done");
  endtask
  task tSecure;
    acc(1, 0, 0, 0, 16'h0804, 1);
    acc(1, 1, 0, 0, 16'h0804, 0);
    acc(0, 0, 0, 0, 16'h0804, 0);
    acc(0, 0, 1, 0, 16'h0904, 1);
    acc(0, 0, 1, 1, 16'h0904, 0);
    dataReq = 0;
    @(negedge sys_clk);
    chk("accessDenied", 16'h0, {15'h0, accessDenied_r});
    $display("test secure done");
  endtask
  task tReset(input logic [15:0] lim);
    srst = 1;
    repeat (2) @(negedge sys_clk);
    srst = 0;
    chk("sp", SPL_SP_RESET, stackPtr_r);
    chk("stackLimit", lim, stackLimit_r);
    errs(3'b000);
    $display("test reset done");
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    srst = 0;
    chk("sp", SPL_SP_RESET, stackPtr_r);
    tPushPop;
    tBounds;
    tSecure;
    tReset(16'h0810);
    endSim;
  end
endmodule
